//--- pkg/ris_pkg.sv
// Purpose : constants, register map and field layout of the remappable input select bank
// Assumes : 32-bit APB, one aligned word per register, at most 12 implemented bits per register (fields 13:8 and 5:0)
// Notes   : What this block does, rule by rule, is listed below
//
// What this block does
// - 9 of the 37 remap registers (21 input, 16 output)
// - selection writes accepted only while unlocked
// - selection fields read/write, reset to ones
// - upper-field registers: bits 15:14 read zero
// - lower-field registers: bits 7:6 read zero
// - register one: interrupt one in 13:8
// - register two: interrupts three and two
// - register three: interrupt four in 5:0
// - register four: timer three/two clocks
// - register five: timer five/four clocks
// - register six: captures two and one
// - register seven: captures four and three
// - register eight: captures six and five
// - register nine: captures eight and seven
// - unimplemented pin values route no pin
// - reset selections tie inputs to ground
`default_nettype none

package ris_pkg;

	// ------------------------------------------------------------
	// bank shape
	// ------------------------------------------------------------
	localparam int TOTAL_REMAP_REGS = 37;
	localparam int INPUT_REMAP_REGS = 21;
	localparam int OUTPUT_REMAP_REGS = 16;
	localparam int NUM_SEL_REGS = 9;
	localparam int NUM_SLOTS = 2 * NUM_SEL_REGS;
	localparam int SEL_W = 6;
	localparam int NUM_PINS = 44;
	localparam int ADDR_W = 12;

	// ------------------------------------------------------------
	// field layout and reset values
	// ------------------------------------------------------------
	localparam int HI_LSB = 8;
	localparam int LO_LSB = 0;
	localparam logic [SEL_W-1:0] SEL_RESET = 6'h3f;
	// bit i set: register i holds that field
	localparam logic [NUM_SEL_REGS-1:0] HI_IMPL = 9'h1fb;
	localparam logic [NUM_SEL_REGS-1:0] LO_IMPL = 9'h1fe;

	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] SEL_OFFSET [NUM_SEL_REGS] = '{
		12'h000, 12'h004, 12'h008, 12'h00c, 12'h010,
		12'h014, 12'h018, 12'h01c, 12'h020};
	localparam logic [ADDR_W-1:0] LOCK_CTRL_OFFSET = 12'h040;

	// ------------------------------------------------------------
	// lock control (oscillator_control_reg low byte)
	// ------------------------------------------------------------
	localparam int LOCK_BIT = 6;
	localparam int ARMED_BIT = 0;
	localparam logic [7:0] UNLOCK_KEY1 = 8'h46;
	localparam logic [7:0] UNLOCK_KEY2 = 8'h57;

	// unlock sequence progress
	typedef enum logic [1:0] {
		RIS_SEQ_IDLE,
		RIS_SEQ_KEY1,
		RIS_SEQ_ARMED
	} ris_seq_t;

endpackage

`default_nettype wire

//--- pkg/ris_route_if.sv
// Purpose : carries selections and synchronised pins to the router and routed levels back
// Assumes : all signals on pclk
// Notes   : slot 2r is the low field of select register r, slot 2r+1 the high field
`default_nettype none

interface ris_route_if #(
	parameter int NSLOT = 18,
	parameter int SELW  = 6,
	parameter int NPIN  = 44
);
	logic [SELW-1:0] sel [NSLOT];
	logic [NPIN-1:0] pins;
	logic [NSLOT-1:0] routed;

	modport ctrl (output sel, output pins, input routed);
	modport mux  (input sel, input pins, output routed);
endinterface

`default_nettype wire

//--- core/ris_pin_router.sv
// Purpose : per-slot pin selector, one registered output per peripheral input
// Assumes : pins already synchronised to pclk
// Notes   : invalid selections drive a steady low so the peripheral sees ground
`default_nettype none

module ris_pin_router
	import ris_pkg::*;
#(
	parameter int                NPIN      = NUM_PINS,
	parameter logic [63:0]       PIN_IMPL  = 64'h0000_0fff_ffff_ffff
) (
	input  wire logic pclk,
	input  wire logic presetn,
	ris_route_if.mux  rt
);

	// ------------------------------------------------------------
	// selection check
	// ------------------------------------------------------------
	// a value names a real pin only if it is in range and built
	function automatic logic sel_valid(input logic [SEL_W-1:0] s);
		sel_valid = (int'(s) < NPIN) && PIN_IMPL[s];
	endfunction

	// ------------------------------------------------------------
	// routing
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_SLOTS; g++) begin : g_slot
			// registered so peripherals never see a mux glitch
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					rt.routed[g] <= 1'b0;
				end else if (sel_valid(rt.sel[g])) begin
					rt.routed[g] <= rt.pins[rt.sel[g]];
				end else begin
					rt.routed[g] <= 1'b0; // no pin: tie low
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

//--- core/ris_input_select_bank.sv
// Purpose : APB register bank that routes remappable pins to peripheral inputs
// Assumes : pins come from pads (asynchronous), APB master on pclk
// Notes   : zero-wait APB; unmapped addresses answer with pslverr
`default_nettype none

module ris_input_select_bank
	import ris_pkg::*;
#(
	parameter int          NPIN     = NUM_PINS,
	parameter logic [63:0] PIN_IMPL = 64'h0000_0fff_ffff_ffff
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [NPIN-1:0]   remappable_io_pin,
	output logic                   pin_config_lock,
	output logic                   ext_irq_one_in,
	output logic                   ext_irq_two_in,
	output logic                   ext_irq_three_in,
	output logic                   ext_irq_four_in,
	output logic                   timer_two_clk_in,
	output logic                   timer_three_clk_in,
	output logic                   timer_four_clk_in,
	output logic                   timer_five_clk_in,
	output logic                   capture_one_in,
	output logic                   capture_two_in,
	output logic                   capture_three_in,
	output logic                   capture_four_in,
	output logic                   capture_five_in,
	output logic                   capture_six_in,
	output logic                   capture_seven_in,
	output logic                   capture_eight_in
);

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	// this bank holds nine of the input selectors; the remaining
	// input and all output selectors live in neighbouring banks
	typedef struct packed {
		logic       sel_hit;
		logic       lock_hit;
		logic [3:0] idx;
	} ris_dec_t;

	// shared by the read path and the write path
	function automatic ris_dec_t decode(input logic [ADDR_W-1:0] a);
		ris_dec_t d;
		d = '0;
		for (int i = 0; i < NUM_SEL_REGS; i++) begin
			if (a == SEL_OFFSET[i]) begin
				d.sel_hit = 1'b1;
				d.idx     = 4'(i);
			end
		end
		d.lock_hit = (a == LOCK_CTRL_OFFSET);
		return d;
	endfunction

	ris_dec_t dec;
	logic     setup_phase;
	logic     access_wr;

	// decode is combinational on the held address
	always_comb begin
		dec         = decode(paddr);
		setup_phase = psel && !penable;
		access_wr   = psel && penable && pwrite;
	end

	// ------------------------------------------------------------
	// selection storage
	// ------------------------------------------------------------
	logic [SEL_W-1:0] hi_q [NUM_SEL_REGS];
	logic [SEL_W-1:0] lo_q [NUM_SEL_REGS];
	logic             lock_q;
	ris_seq_t         seq_q;
	logic             sel_wr;

	// writes are dropped while locked, yet the bus still completes
	always_comb begin
		sel_wr = access_wr && dec.sel_hit && !lock_q;
	end

	genvar r;
	generate
		for (r = 0; r < NUM_SEL_REGS; r++) begin : g_reg
			// high field, bits 13:8; absent fields never leave reset
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					hi_q[r] <= SEL_RESET; // all ones at reset
				end else if (sel_wr && dec.idx == 4'(r) && HI_IMPL[r]) begin
					hi_q[r] <= pwdata[HI_LSB +: SEL_W];
				end
			end
			// low field, bits 5:0
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					lo_q[r] <= SEL_RESET;
				end else if (sel_wr && dec.idx == 4'(r) && LO_IMPL[r]) begin
					lo_q[r] <= pwdata[LO_LSB +: SEL_W];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// lock control and unlock sequence
	// ------------------------------------------------------------
	// the key pair must be the two writes straight before the lock
	// write; any other bank write in between disarms the sequence
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_q <= RIS_SEQ_IDLE;
		end else if (access_wr) begin
			if (!dec.lock_hit) begin
				seq_q <= RIS_SEQ_IDLE;
			end else begin
				case (seq_q)
					RIS_SEQ_IDLE: begin
						seq_q <= (pwdata[7:0] == UNLOCK_KEY1) ? RIS_SEQ_KEY1 : RIS_SEQ_IDLE;
					end
					RIS_SEQ_KEY1: begin
						if (pwdata[7:0] == UNLOCK_KEY2) begin
							seq_q <= RIS_SEQ_ARMED;
						end else if (pwdata[7:0] == UNLOCK_KEY1) begin
							seq_q <= RIS_SEQ_KEY1;
						end else begin
							seq_q <= RIS_SEQ_IDLE;
						end
					end
					RIS_SEQ_ARMED: begin
						seq_q <= RIS_SEQ_IDLE; // one lock write per sequence
					end
					default: begin
						seq_q <= RIS_SEQ_IDLE;
					end
				endcase
			end
		end
	end

	// lock bit resets open so boot code may configure without a sequence
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_q <= 1'b0;
		end else if (access_wr && dec.lock_hit && seq_q == RIS_SEQ_ARMED) begin
			lock_q <= pwdata[LOCK_BIT]; // set or clear in one write
		end
	end

	always_comb begin
		pin_config_lock = lock_q;
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	logic [31:0] rdata_d;
	logic [31:0] prdata_q;
	logic        err_d;
	logic        err_q;

	// unimplemented bits and absent fields always read zero
	always_comb begin
		rdata_d = 32'h0000_0000;
		err_d   = 1'b0;
		if (dec.sel_hit) begin
			for (int i = 0; i < NUM_SEL_REGS; i++) begin
				if (dec.idx == 4'(i)) begin
					if (HI_IMPL[i]) begin
						rdata_d[HI_LSB +: SEL_W] = hi_q[i]; // 15:14 stay zero
					end
					if (LO_IMPL[i]) begin
						rdata_d[LO_LSB +: SEL_W] = lo_q[i]; // 7:6 stay zero
					end
				end
			end
		end else if (dec.lock_hit) begin
			rdata_d[LOCK_BIT]  = lock_q;
			rdata_d[ARMED_BIT] = (seq_q == RIS_SEQ_ARMED);
		end else begin
			err_d = 1'b1;
		end
	end

	// answer is prepared during setup so prdata comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
			err_q    <= 1'b0;
		end else if (setup_phase) begin
			prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
			err_q    <= err_d;
		end
	end

	// zero-wait slave; a locked write is not an error
	always_comb begin
		pready  = 1'b1;
		prdata  = (psel && penable && !pwrite) ? prdata_q : 32'h0000_0000;
		pslverr = psel && penable && err_q;
	end

	// ------------------------------------------------------------
	// pad synchroniser
	// ------------------------------------------------------------
	// pins are asynchronous; two flops before the router reads them
	logic [NPIN-1:0] pin_meta_q;
	logic [NPIN-1:0] pin_sync_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
		end else begin
			pin_meta_q <= remappable_io_pin;
			pin_sync_q <= pin_meta_q;
		end
	end

	// ------------------------------------------------------------
	// router
	// ------------------------------------------------------------
	ris_route_if #(
		.NSLOT (NUM_SLOTS),
		.SELW  (SEL_W),
		.NPIN  (NPIN)
	) route ();

	// slot 2r carries the low field of register r, 2r+1 the high field
	generate
		for (r = 0; r < NUM_SEL_REGS; r++) begin : g_slot
			assign route.sel[2*r]   = lo_q[r];
			assign route.sel[2*r+1] = hi_q[r];
		end
	endgenerate

	assign route.pins = pin_sync_q;

	ris_pin_router #(
		.NPIN     (NPIN),
		.PIN_IMPL (PIN_IMPL)
	) u_router (
		.pclk    (pclk),
		.presetn (presetn),
		.rt      (route)
	);

	// ------------------------------------------------------------
	// peripheral input map
	// ------------------------------------------------------------
	// slots 0 and 5 belong to absent fields and stay low
	assign ext_irq_one_in     = route.routed[1];  // reg 0, 13:8
	assign ext_irq_two_in     = route.routed[2];  // reg 1, 5:0
	assign ext_irq_three_in   = route.routed[3];  // reg 1, 13:8
	assign ext_irq_four_in    = route.routed[4];  // reg 2, 5:0
	assign timer_two_clk_in   = route.routed[6];
	assign timer_three_clk_in = route.routed[7];
	assign timer_four_clk_in  = route.routed[8];
	assign timer_five_clk_in  = route.routed[9];
	assign capture_one_in     = route.routed[10];
	assign capture_two_in     = route.routed[11];
	assign capture_three_in   = route.routed[12];
	assign capture_four_in    = route.routed[13];
	assign capture_five_in    = route.routed[14];
	assign capture_six_in     = route.routed[15];
	assign capture_seven_in   = route.routed[16];
	assign capture_eight_in   = route.routed[17];

endmodule

`default_nettype wire

//--- bench/ris_assertions.sv
// Purpose: port-level checks of the input select bank
// Assumes: zero-wait APB, lock control word at LOCK_CTRL_OFFSET
// Notes  : bound to every instance of the bank
`default_nettype none
module ris_assertions
	import ris_pkg::*;
(
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              pin_config_lock,
	input wire logic              ext_irq_one_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic lk_wr_q;
	logic lk_val_q;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// -------------------------------
	// helper: last cycle was a lock control write
	// -------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lk_wr_q  <= 1'b0;
			lk_val_q <= 1'b0;
		end else begin
			lk_wr_q  <= psel && penable && pwrite && paddr == LOCK_CTRL_OFFSET;
			lk_val_q <= pwdata[LOCK_BIT];
		end
	end
	sequence s_rd;
		psel && penable && !pwrite;
	endsequence
	sequence s_wr_sel;
		psel && penable && pwrite && paddr <= SEL_OFFSET[8] && paddr[1:0] == 2'h0;
	endsequence
	a_ready_high: assert property (psel && penable |-> pready) else $error("slave stalled");
	a_locked_no_err: assert property (s_wr_sel ##0 pin_config_lock |-> !pslverr)
		else $error("locked write flagged");
	a_upper_zero: assert property (s_rd |-> prdata[31:14] == 18'h0) else $error("upper bits set");
	a_lower_gap: assert property (s_rd ##0 (paddr <= SEL_OFFSET[8]) |-> prdata[7:6] == 2'h0)
		else $error("gap bits set");
	a_reg_one_low: assert property (s_rd ##0 (paddr == SEL_OFFSET[0]) |-> prdata[7:0] == 8'h0)
		else $error("first reg low byte set");
	a_reg_three_hi: assert property (s_rd ##0 (paddr == SEL_OFFSET[2]) |-> prdata[15:8] == 8'h0)
		else $error("third reg high byte set");
	// lock moves only right after a lock write, and to the written bit
	a_lock_by_write: assert property ($changed(pin_config_lock) |-> lk_wr_q && pin_config_lock == lk_val_q)
		else $error("lock moved alone");
	a_reset_quiet: assert property (!$past(presetn) |-> !pin_config_lock && !ext_irq_one_in)
		else $error("not quiet after reset");
endmodule
bind ris_input_select_bank ris_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .pin_config_lock, .ext_irq_one_in);
`default_nettype wire

//--- bench/ris_pad_model.sv
// Purpose: pad side of the bank, drives remappable pin levels
// Assumes: the bank synchronises pads itself
// Notes  : pads are always driven, so no pin floats
`default_nettype none
module ris_pad_model
	import ris_pkg::*;
(
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic [NUM_PINS-1:0] level_req,
	output logic      [NUM_PINS-1:0] remappable_io_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// pads held low in reset, then follow the requested levels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) remappable_io_pin <= '0;
		else remappable_io_pin <= level_req;
	end
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// Purpose: self-checking bench of the input select bank
// Assumes: zero-wait APB, routing latency under six cycles
// Notes  : slot 2r is the low field of select register r
`default_nettype none
module tb_top
	import ris_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pin_config_lock, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, ex;
	logic [43:0] lvl, remappable_io_pin;
	logic ext_irq_one_in, ext_irq_two_in, ext_irq_three_in, ext_irq_four_in, timer_two_clk_in, timer_three_clk_in;
	logic timer_four_clk_in, timer_five_clk_in, capture_one_in, capture_two_in, capture_three_in, capture_four_in;
	logic capture_five_in, capture_six_in, capture_seven_in, capture_eight_in;
	int err_total, n_tests, cyc;
	wire logic [17:0] route_w = {capture_eight_in, capture_seven_in, capture_six_in, capture_five_in,
		capture_four_in, capture_three_in, capture_two_in, capture_one_in, timer_five_clk_in, timer_four_clk_in,
		timer_three_clk_in, timer_two_clk_in, 1'b0, ext_irq_four_in, ext_irq_three_in, ext_irq_two_in,
		ext_irq_one_in, 1'b0};
	ris_input_select_bank uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .remappable_io_pin, .pin_config_lock, .ext_irq_one_in, .ext_irq_two_in, .ext_irq_three_in,
		.ext_irq_four_in, .timer_two_clk_in, .timer_three_clk_in, .timer_four_clk_in, .timer_five_clk_in,
		.capture_one_in, .capture_two_in, .capture_three_in, .capture_four_in, .capture_five_in,
		.capture_six_in, .capture_seven_in, .capture_eight_in);
	ris_pad_model pads (.pclk, .presetn, .level_req(lvl), .remappable_io_pin);
	// ---------------------------
	// shared tasks
	// ---------------------------
	task chk(input logic [31:0] seen, input logic [31:0] want);
		n_tests++;
		if (seen !== want) begin
			err_total++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	// setup, then access held until pready is seen high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task key(input logic [31:0] v);
		apb(1'b1, LOCK_CTRL_OFFSET, 32'h0000_0046);
		apb(1'b1, LOCK_CTRL_OFFSET, 32'h0000_0057);
		apb(1'b1, LOCK_CTRL_OFFSET, v);
	endtask
	function automatic logic [31:0] sel_word(int r, logic [5:0] hi, logic [5:0] lo);
		return {18'h0, HI_IMPL[r] ? hi : 6'h0, 2'h0, LO_IMPL[r] ? lo : 6'h0};
	endfunction
	task end_of_test;
		$display("comparisons %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// ---------------------------
	// scenarios
	// ---------------------------
	task t_reset;
		for (int r = 0; r < NUM_SEL_REGS; r++) begin
			apb(1'b0, SEL_OFFSET[r], 32'h0);
			chk(rd, sel_word(r, SEL_RESET, SEL_RESET));
		end
		chk({14'h0, route_w}, 32'h0);
		$display("reset test done");
	endtask
	// junk in unused bits must be dropped; slot s routes pin s+20, except absent slots 0 and 5, which route none
	task t_route;
		for (int r = 0; r < NUM_SEL_REGS; r++) begin
			apb(1'b1, SEL_OFFSET[r], {16'hffff, 2'h3, 6'(2*r+21), 2'h3, 6'(2*r+20)});
			apb(1'b0, SEL_OFFSET[r], 32'h0);
			chk(rd, sel_word(r, 6'(2*r+21), 6'(2*r+20)));
		end
		for (int p = 0; p < 2; p++) begin
			lvl <= p ? 44'haaa_aaaa_aaaa : 44'h555_5555_5555;
			repeat (6) @(posedge pclk);
			for (int s = 0; s < NUM_SLOTS; s++) ex[s] = (s == 0 || s == 5) ? 1'b0 : lvl[s+20];
			chk({22'h0, route_w[9:0]}, {22'h0, ex[9:0]});
			chk({24'h0, route_w[17:10]}, {24'h0, ex[17:10]});
		end
		$display("route test done");
	endtask
	// pin 43 is the last valid one, 44 routes nothing
	task t_invalid;
		apb(1'b1, SEL_OFFSET[1], 32'h0000_2c2b);
		lvl <= '1;
		repeat (6) @(posedge pclk);
		chk({30'h0, ext_irq_three_in, ext_irq_two_in}, 32'h0000_0001);
		apb(1'b0, 12'h100, 32'h0);
		chk({er, rd[30:0]}, 32'h8000_0000);
		$display("invalid pin test done");
	endtask
	task t_lock;
		key(32'h0000_0040);
		// the lock flop updates at the access edge; look one edge later
		@(posedge pclk);
		chk({31'h0, pin_config_lock}, 32'h1);
		apb(1'b1, SEL_OFFSET[3], 32'h0);
		chk({31'h0, er}, 32'h0);
		apb(1'b0, SEL_OFFSET[3], 32'h0);
		chk(rd, sel_word(3, 6'd27, 6'd26));
		key(32'h0);
		apb(1'b1, LOCK_CTRL_OFFSET, 32'h0000_0040);
		@(posedge pclk);
		chk({31'h0, pin_config_lock}, 32'h0);
		apb(1'b1, SEL_OFFSET[3], 32'h0);
		apb(1'b0, SEL_OFFSET[3], 32'h0);
		chk(rd, 32'h0);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, SEL_OFFSET[3], 32'h0);
		chk(rd, 32'h0000_3f3f);
		$display("lock test done");
	endtask
	// ---------------------------
	// clock, watchdog, main
	// ---------------------------
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// a hang counts as a mismatch and closes the run
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			end_of_test();
		end
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		lvl = '1;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_route();
		t_invalid();
		t_lock();
		end_of_test();
	end
endmodule
`default_nettype wire
